// file: design/csr_map.svh
/*
 * Control values, field positions, counts and widths of the remote-frame
 * slot handler.
 * Assumes inclusion by bare name from the package and the main module.
 */
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// Slot control register bit positions
`define CSR_BIT_TX_REQ      7
`define CSR_BIT_RX_REQ      6
`define CSR_BIT_REMOTE      5
`define CSR_BIT_INHIBIT     4
`define CSR_BIT_ABORT       3
`define CSR_BIT_ML_EN       2
`define CSR_BIT_ML_EN2      1

// Control values software writes
`define CSR_CMD_STOP        8'h00
`define CSR_CMD_RTX         8'hA0
`define CSR_CMD_RTX_ML      8'hAE
`define CSR_CMD_RRX_ANS     8'h60
`define CSR_CMD_RRX_NOANS   8'h70

// Slot count and the two slots special in basic mailbox mode
`define CSR_SLOTS           16
`define CSR_BASIC_SLOT_A    14
`define CSR_BASIC_SLOT_B    15

// Frame field widths
`define CSR_ID_W            29
`define CSR_DLC_W           4
`define CSR_TS_W            16
`define CSR_DATA_W          64

`endif

// file: design/csr_pkg.sv
/*
 * Types shared by the remote-frame slot handler.
 * Assumes csr_map.svh is on the include path.
 */
`include "csr_map.svh"

package csr_pkg;

    // One frame as seen from the bus side
    typedef struct packed {
        logic [`CSR_ID_W-1:0]   id;
        logic                   ext;
        logic                   remote;
        logic [`CSR_DLC_W-1:0]  dlc;
        logic [`CSR_DATA_W-1:0] data;
    } csr_frame_t;

    // Per-slot operating mode
    typedef enum logic [2:0] {
        CSR_IDLE    = 3'b000,
        CSR_RTX     = 3'b001,
        CSR_RTX_RX  = 3'b010,
        CSR_RRX     = 3'b011,
        CSR_ANS_TX  = 3'b100
    } csr_mode_t;

    // Bus-side sequencer
    typedef enum logic [1:0] {
        CSR_S_IDLE  = 2'b00,
        CSR_S_TX    = 2'b01,
        CSR_S_STORE = 2'b10
    } csr_seq_t;

endpackage

// file: design/csr_buf2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and active-low asynchronous reset.
 */
`timescale 1ns/1ps

module csr_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    logic [W-1:0] mem_r [2];
    logic         wptr_r;
    logic         rptr_r;
    logic [1:0]   cnt_r;
    logic         push;
    logic         pop;

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_r[rptr_r];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r  <= 2'h0;
        end else begin
            if (push) begin
                wptr_r <= ~wptr_r;
            end
            if (pop) begin
                rptr_r <= ~rptr_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // csr_buf2

// file: design/csr_slots.sv
/*
 * Remote-frame handling for sixteen message slots of a CAN controller:
 * remote transmit with data answer, remote receive with automatic answer.
 * Assumes a bus engine that hands received frames in through a stream,
 * pulses intermission, and reports transmit end, loss and error.
 */
// Notes on behaviour
// - Answer data frame sets status, finished, lost
// - Store overwrites identifier and length code
// - Store time stamp, interrupt status, wait
// - Early data frame cancels pending remote request
// - Unmatched frame discarded, no slot written
// - 0xAE keeps receiving, 0x00 stops slot
// - 0xA0 restarts remote frame transmission
// - Extended bit selects standard or extended
// - 0x60 answers automatically, 0x70 inhibits
// - Remote-receive write sets remote active
// - Basic mode slots 14,15 never answer
// - Search slots 0 to 15 with mask
// - Remote match stores id, length, no data
// - Remote store clears remote active, finished
// - Inhibited answer leaves slot inactive
// - Answer slot transmits received id, length
// - Lowest pending slot sent at intermission
// - Loss or error clears transfer status
// - Answer sent sets finished, stamps, inactive
`timescale 1ns/1ps
`include "csr_map.svh"

module csr_slots #(
    parameter int NS = `CSR_SLOTS
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // Software control write
    input  wire logic                    ctl_we_i,
    input  wire logic [3:0]              ctl_slot_i,
    input  wire logic [7:0]              ctl_data_i,
    input  wire logic [NS-1:0]           ext_sel_i,
    input  wire logic [`CSR_ID_W-1:0]    id_mask_i,
    input  wire logic                    basic_mailbox_mode_i,
    input  wire logic [NS*`CSR_ID_W-1:0] slot_id_i,
    input  wire logic [`CSR_TS_W-1:0]    time_stamp_i,
    // Received frame stream
    input  wire logic                    rx_valid_i,
    output logic                         rx_ready_o,
    input  wire csr_pkg::csr_frame_t     rx_frame_i,
    // Transmit engine
    input  wire logic                    intermission_i,
    output logic                         tx_start_o,
    output logic [3:0]                   tx_slot_o,
    output logic                         tx_remote_o,
    input  wire logic                    tx_done_i,
    input  wire logic                    tx_fail_i,
    // Slot state seen by software
    output logic [NS-1:0]                transfer_status_flag_o,
    output logic [NS-1:0]                transfer_finished_flag_o,
    output logic [NS-1:0]                message_lost_flag_o,
    output logic [NS-1:0]                remote_active_flag_o,
    output logic [NS-1:0]                auto_answer_inhibit_bit_o,
    output logic [NS-1:0]                slot_int_status_o,
    // Slot store port
    output logic                         st_we_o,
    output logic [3:0]                   st_slot_o,
    output logic                         st_data_we_o,
    output csr_pkg::csr_frame_t          st_frame_o,
    output logic [`CSR_TS_W-1:0]         slot_time_stamp_reg_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    csr_pkg::csr_mode_t  mode_r [NS];
    csr_pkg::csr_seq_t   seq_r;
    logic [NS-1:0]       tst_r;
    logic [NS-1:0]       fin_r;
    logic [NS-1:0]       ml_r;
    logic [NS-1:0]       ra_r;
    logic [NS-1:0]       inh_r;
    logic [NS-1:0]       mlen_r;
    logic [NS-1:0]       ist_r;
    logic [3:0]          cur_r;
    logic                buf_valid;
    logic                buf_ready;
    csr_pkg::csr_frame_t buf_frame;
    logic                hit;
    logic [3:0]          hit_slot;
    logic                pend;
    logic [3:0]          pend_slot;
    logic [NS-1:0]       wr_vec;
    logic [NS-1:0]       st_vec;
    logic [NS-1:0]       done_vec;
    logic [NS-1:0]       fail_vec;
    logic [NS-1:0]       start_vec;

    ////////////////////////////////////////////////////////////////////////
    // Input buffer keeps frames while the sequencer is busy

    csr_buf2 #(
        .W ($bits(csr_pkg::csr_frame_t))
    ) u_buf (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_frame_i),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_ready),
        .out_data_o  (buf_frame)
    );

    ////////////////////////////////////////////////////////////////////////
    // Acceptance

    function automatic logic slot_match(
        input csr_pkg::csr_mode_t   m,
        input logic [`CSR_ID_W-1:0] sid,
        input logic                 sext,
        input csr_pkg::csr_frame_t  f
    );
        logic want_remote;
        logic live;
        want_remote = (m == csr_pkg::CSR_RRX);
        live = (m == csr_pkg::CSR_RTX) || (m == csr_pkg::CSR_RTX_RX) ||
               (m == csr_pkg::CSR_RRX);
        return live && (f.remote == want_remote) && (f.ext == sext) &&
               (((f.id ^ sid) & id_mask_i) == '0);
    endfunction

    always_comb begin
        hit      = 1'b0;
        hit_slot = 4'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (slot_match(mode_r[i], slot_id_i[i*`CSR_ID_W +: `CSR_ID_W],
                           ext_sel_i[i], buf_frame)) begin
                hit      = 1'b1;
                hit_slot = 4'(i);
            end
        end
    end

    always_comb begin
        pend      = 1'b0;
        pend_slot = 4'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (((mode_r[i] == csr_pkg::CSR_RTX) ||
                 (mode_r[i] == csr_pkg::CSR_ANS_TX)) && !tst_r[i]) begin
                pend      = 1'b1;
                pend_slot = 4'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one store or one transmission at a time

    assign buf_ready = (seq_r == csr_pkg::CSR_S_IDLE) && !intermission_i;
    assign tx_start_o = (seq_r == csr_pkg::CSR_S_IDLE) && intermission_i &&
                        pend;

    always_comb begin
        wr_vec    = '0;
        st_vec    = '0;
        done_vec  = '0;
        fail_vec  = '0;
        start_vec = '0;
        if (ctl_we_i) begin
            wr_vec[ctl_slot_i] = 1'b1;
        end
        if (buf_valid && buf_ready && hit) begin
            st_vec[hit_slot] = 1'b1;
        end
        if (tx_start_o) begin
            start_vec[pend_slot] = 1'b1;
        end
        if (seq_r == csr_pkg::CSR_S_TX) begin
            done_vec[cur_r] = tx_done_i;
            fail_vec[cur_r] = tx_fail_i && !tx_done_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_r <= csr_pkg::CSR_S_IDLE;
            cur_r <= 4'h0;
        end else begin
            unique case (seq_r)
                csr_pkg::CSR_S_IDLE: begin
                    if (tx_start_o) begin
                        seq_r <= csr_pkg::CSR_S_TX;
                        cur_r <= pend_slot;
                    end else if (buf_valid && buf_ready && hit) begin
                        seq_r <= csr_pkg::CSR_S_STORE;
                        cur_r <= hit_slot;
                    end
                end
                csr_pkg::CSR_S_TX: begin
                    if (tx_done_i || tx_fail_i) begin
                        seq_r <= csr_pkg::CSR_S_IDLE;
                    end
                end
                csr_pkg::CSR_S_STORE: begin
                    seq_r <= csr_pkg::CSR_S_IDLE;
                end
                default: begin
                    seq_r <= csr_pkg::CSR_S_IDLE;
                end
            endcase
        end
    end

    assign tx_slot_o   = cur_r;
    assign tx_remote_o = (mode_r[cur_r] == csr_pkg::CSR_RTX);

    ////////////////////////////////////////////////////////////////////////
    // Store port, registered

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_we_o               <= 1'b0;
            st_data_we_o          <= 1'b0;
            st_slot_o             <= 4'h0;
            st_frame_o            <= '0;
            slot_time_stamp_reg_o <= '0;
        end else begin
            st_we_o      <= (|st_vec) || (|done_vec);
            st_data_we_o <= (|st_vec) && !buf_frame.remote;
            if (|st_vec) begin
                st_slot_o  <= hit_slot;
                st_frame_o <= buf_frame;
                slot_time_stamp_reg_o <= time_stamp_i;
            end else if (|done_vec) begin
                st_slot_o  <= cur_r;
                // Frame held: carries the last stored id and length
                // time stamp on answer
                slot_time_stamp_reg_o <= time_stamp_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-slot control and status

    for (genvar g = 0; g < NS; g++) begin : g_slot
        logic basic_slot;
        assign basic_slot = basic_mailbox_mode_i &&
                            ((g == `CSR_BASIC_SLOT_A) ||
                             (g == `CSR_BASIC_SLOT_B));

        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mode_r[g] <= csr_pkg::CSR_IDLE;
                tst_r[g]  <= 1'b0;
                fin_r[g]  <= 1'b0;
                ml_r[g]   <= 1'b0;
                ra_r[g]   <= 1'b0;
                inh_r[g]  <= 1'b0;
                mlen_r[g] <= 1'b0;
                ist_r[g]  <= 1'b0;
            end else if (st_vec[g]) begin
                // Hardware events win over a software write; a stop write still applies on a loss or error
                ist_r[g] <= 1'b1;
                tst_r[g] <= 1'b1;
                if (buf_frame.remote) begin
                    fin_r[g] <= 1'b0;
                    ra_r[g]  <= 1'b0;
                    mode_r[g] <= (inh_r[g] || basic_slot) ?
                                 csr_pkg::CSR_IDLE : csr_pkg::CSR_ANS_TX;
                end else begin
                    fin_r[g]  <= 1'b1;
                    ml_r[g]   <= ml_r[g] | (fin_r[g] & mlen_r[g]);
                    ra_r[g]   <= 1'b0;
                    mode_r[g] <= csr_pkg::CSR_RTX_RX;
                end
            end else if (done_vec[g]) begin
                tst_r[g] <= 1'b0;
                ist_r[g] <= 1'b1;
                if (mode_r[g] == csr_pkg::CSR_RTX) begin
                    ra_r[g]   <= 1'b0;
                    mode_r[g] <= csr_pkg::CSR_RTX_RX;
                end else begin
                    fin_r[g]  <= 1'b1;
                    mode_r[g] <= csr_pkg::CSR_IDLE;
                end
            end else if (fail_vec[g]) begin
                tst_r[g] <= 1'b0;
                if (wr_vec[g] && ctl_data_i == `CSR_CMD_STOP) begin
                    mode_r[g] <= csr_pkg::CSR_IDLE;
                end
            end else if (start_vec[g]) begin
                tst_r[g] <= 1'b1;
            end else if (wr_vec[g] && !(tst_r[g] &&
                         seq_r == csr_pkg::CSR_S_TX && cur_r == 4'(g))) begin
                fin_r[g]  <= 1'b0;
                ml_r[g]   <= 1'b0;
                tst_r[g]  <= 1'b0;
                mlen_r[g] <= ctl_data_i[`CSR_BIT_ML_EN];
                inh_r[g]  <= ctl_data_i[`CSR_BIT_INHIBIT];
                if (ctl_data_i == `CSR_CMD_RTX_ML) begin
                    mode_r[g] <= csr_pkg::CSR_RTX_RX;
                end else if (ctl_data_i == `CSR_CMD_RTX) begin
                    mode_r[g] <= basic_slot ? csr_pkg::CSR_IDLE
                                            : csr_pkg::CSR_RTX;
                    ra_r[g]   <= !basic_slot;
                end else if (ctl_data_i == `CSR_CMD_RRX_ANS ||
                             ctl_data_i == `CSR_CMD_RRX_NOANS) begin
                    mode_r[g] <= csr_pkg::CSR_RRX;
                    ra_r[g]   <= 1'b1;
                end else begin
                    mode_r[g] <= csr_pkg::CSR_IDLE;
                    ra_r[g]   <= 1'b0;
                end
            end else if (seq_r == csr_pkg::CSR_S_STORE && cur_r == 4'(g) &&
                         mode_r[g] != csr_pkg::CSR_ANS_TX) begin
                tst_r[g] <= 1'b0;
            end else if (seq_r == csr_pkg::CSR_S_STORE && cur_r == 4'(g)) begin
                tst_r[g] <= 1'b0;
            end
        end
    end

    assign transfer_status_flag_o    = tst_r;
    assign transfer_finished_flag_o  = fin_r;
    assign message_lost_flag_o       = ml_r;
    assign remote_active_flag_o      = ra_r;
    assign auto_answer_inhibit_bit_o = inh_r;
    assign slot_int_status_o         = ist_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_DATA_SETS_FIN: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (|st_vec) && !buf_frame.remote |=> fin_r[$past(hit_slot)])
        else $error("data store did not set finished");

    AST_LOST: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (|st_vec) && !buf_frame.remote && fin_r[hit_slot] &&
        mlen_r[hit_slot] |=> ml_r[$past(hit_slot)])
        else $error("overwrite did not set lost flag");

    AST_STAMP: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (|st_vec) |=> st_we_o &&
        slot_time_stamp_reg_o == $past(time_stamp_i))
        else $error("time stamp not written");

    AST_NO_WRITE: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        buf_valid && buf_ready && !hit && !(|done_vec) |=> !st_we_o)
        else $error("unmatched frame wrote a slot");

    AST_RA_SET: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ctl_we_i && ctl_data_i == `CSR_CMD_RRX_ANS && (|st_vec) == 1'b0 &&
        (|done_vec) == 1'b0 && (|fail_vec) == 1'b0 && !(|start_vec) &&
        seq_r == csr_pkg::CSR_S_IDLE |=> ra_r[$past(ctl_slot_i)])
        else $error("remote active not set");

    AST_REMOTE_CLR: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (|st_vec) && buf_frame.remote |=>
        !ra_r[$past(hit_slot)] && !fin_r[$past(hit_slot)] &&
        !st_data_we_o)
        else $error("remote store left flags set");

    AST_START_TST: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        tx_start_o |=> tst_r[$past(pend_slot)] &&
        seq_r == csr_pkg::CSR_S_TX)
        else $error("transmit start did not set status");

    AST_FAIL_CLR: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (|fail_vec) |=> !tst_r[$past(cur_r)] &&
        seq_r == csr_pkg::CSR_S_IDLE)
        else $error("loss did not clear status");

endmodule // csr_slots

// file: tb/csr_bus_node.sv
/*
 * Other nodes on the shared bus, as seen by the slot handler: paces
 * intermissions and ends each transmission with a done or fail pulse.
 * Assumes one clock, active-low asynchronous reset, requests at tx_start.
 */
`timescale 1ns/1ps

module csr_bus_node #(
    parameter int LAT = 12
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic tx_start_i,
    input  wire logic int_en_i,
    input  wire logic fail_next_i,
    output logic      intermission_o,
    output logic      tx_done_o,
    output logic      tx_fail_o
);
    logic [2:0] gap_r;
    logic [7:0] busy_r;

    ////////////////////////////////////////////////////////////////////////
    // intermission pacing, end of frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_r          <= 3'h0;
            busy_r         <= 8'h00;
            intermission_o <= 1'b0;
            tx_done_o      <= 1'b0;
            tx_fail_o      <= 1'b0;
        end else begin
            intermission_o <= 1'b0;
            tx_done_o      <= 1'b0;
            tx_fail_o      <= 1'b0;
            if (busy_r != 8'h00) begin
                busy_r <= busy_r - 8'h01;
                if (busy_r == 8'h01) begin
                    tx_fail_o <= fail_next_i;
                    tx_done_o <= !fail_next_i;
                end
            end else if (tx_start_i) begin
                busy_r <= 8'(LAT);
                gap_r  <= 3'h0;
            end else if (int_en_i) begin
                gap_r          <= gap_r + 3'h1;
                intermission_o <= (gap_r == 3'h7);
            end
        end
    end
endmodule // csr_bus_node

// file: tb/can_slot_remote_frame_handling_bench.sv
/*
 * Self-checking bench of the remote-frame slot handler, random ids,
 * masks and stamps with fixed corner cases.
 * Assumes the design package, csr_slots and csr_bus_node compiled first.
 */
`timescale 1ns/1ps
`include "csr_map.svh"

module can_slot_remote_frame_handling_bench;
    localparam int W = `CSR_ID_W;
    logic                 clock_i    = 1'b0;
    logic                 rst_n_i    = 1'b0;
    logic                 ctl_we_i   = 1'b0;
    logic [3:0]           ctl_slot_i = 4'h0;
    logic [7:0]           ctl_data_i = 8'h00;
    logic [15:0]          ext_sel_i  = 16'h0000;
    logic [W-1:0]         id_mask_i  = '1;
    logic                 basic_i    = 1'b0;
    logic [16*W-1:0]      slot_id_i  = '0;
    logic [15:0]          ts_i       = 16'h0000;
    logic                 rx_valid_i = 1'b0;
    csr_pkg::csr_frame_t  rx_frame_i = '0;
    csr_pkg::csr_frame_t  sent, st_frame;
    logic                 int_en = 1'b1, fail_next = 1'b0;
    logic                 rx_ready, intermission, tx_start, tx_done, tx_fail;
    logic                 tx_remote, st_we, st_data_we;
    logic [3:0]           tx_slot, st_slot;
    logic [15:0]          tst, fin, lost, ract, inh, isr, st_ts;
    int                   fail_count = 0;
    int                   cmp_count  = 0;

    always #5 clock_i = ~clock_i;

    csr_slots DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl_we_i(ctl_we_i),
        .ctl_slot_i(ctl_slot_i), .ctl_data_i(ctl_data_i),
        .ext_sel_i(ext_sel_i), .id_mask_i(id_mask_i),
        .basic_mailbox_mode_i(basic_i), .slot_id_i(slot_id_i),
        .time_stamp_i(ts_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready),
        .rx_frame_i(rx_frame_i), .intermission_i(intermission),
        .tx_start_o(tx_start), .tx_slot_o(tx_slot), .tx_remote_o(tx_remote),
        .tx_done_i(tx_done), .tx_fail_i(tx_fail),
        .transfer_status_flag_o(tst), .transfer_finished_flag_o(fin),
        .message_lost_flag_o(lost), .remote_active_flag_o(ract),
        .auto_answer_inhibit_bit_o(inh), .slot_int_status_o(isr),
        .st_we_o(st_we), .st_slot_o(st_slot), .st_data_we_o(st_data_we),
        .st_frame_o(st_frame), .slot_time_stamp_reg_o(st_ts));

    csr_bus_node NODE (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .tx_start_i(tx_start), .int_en_i(int_en), .fail_next_i(fail_next),
        .intermission_o(intermission), .tx_done_o(tx_done),
        .tx_fail_o(tx_fail));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic ctl(input int s, input logic [7:0] v);
        @(negedge clock_i);
        ctl_we_i   = 1'b1;
        ctl_slot_i = 4'(s);
        ctl_data_i = v;
        @(negedge clock_i);
        ctl_we_i   = 1'b0;
    endtask

    // Don't-care id bits are scrambled, so the mask is exercised
    task automatic send(input int s, input logic rem, input logic flip);
        int k;
        @(negedge clock_i);
        ts_i        = 16'($urandom);
        sent.id     = slot_id_i[s*W+:W] ^ (W'($urandom) & ~id_mask_i);
        sent.ext    = ext_sel_i[s] ^ flip;
        sent.remote = rem;
        sent.dlc    = 4'($urandom_range(8));
        sent.data   = {$urandom, $urandom};
        rx_frame_i  = sent;
        rx_valid_i  = 1'b1;
        k = 0;
        // Ready is registered, so its value here holds at the next edge
        while (rx_ready !== 1'b1 && k < 50) begin
            @(negedge clock_i);
            k++;
        end
        chk("rx_ready", 1, rx_ready);
        @(negedge clock_i);
        rx_valid_i = 1'b0;
        rx_frame_i = ~sent;
    endtask

    task automatic wait_store(input int s, input logic dw, input logic cdw);
        int k;
        k = 0;
        while (st_we !== 1'b1 && k < 80) begin
            @(negedge clock_i);
            k++;
        end
        chk("st_we", 1, st_we);
        chk("st_slot", s, st_slot);
        if (cdw) chk("st_data_we", dw, st_data_we);
        chk("st_id", sent.id, st_frame.id);
        chk("st_dlc", sent.dlc, st_frame.dlc);
        chk("st_stamp", ts_i, st_ts);
        repeat (2) @(negedge clock_i);
    endtask

    task automatic wait_tx(input int s, input logic rem);
        int k;
        k = 0;
        while (tx_start !== 1'b1 && k < 300) begin
            @(negedge clock_i);
            k++;
        end
        chk("tx_start", 1, tx_start);
        // Slot and kind come from the sequencer register, one cycle on
        @(negedge clock_i);
        chk("tx_slot", s, tx_slot);
        chk("tx_remote", rem, tx_remote);
        chk("tst_on", 1, tst[s]);
    endtask

    task automatic quiet(input int n, input logic st_too);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge clock_i);
            if (tx_start === 1'b1 || (st_too && st_we === 1'b1)) hits++;
        end
        chk("quiet", 0, hits);
    endtask

    task automatic complete_run;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fail_count++;
        complete_run();
    end

    initial begin
        void'($urandom(11655));
        id_mask_i = W'($urandom) | W'(4'hF);
        ext_sel_i = 16'($urandom);
        for (int i = 0; i < 16; i++) slot_id_i[i*W+:W] = {25'($urandom), 4'(i)};
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'b1;
        ctl(2, 8'h00);
        chk("tst_idle", 0, tst[2]);
        ctl(2, 8'h70);
        chk("ract", 1, ract[2]);
        chk("inh", 1, inh[2]);
        send(2, 1'b1, 1'b1);
        quiet(40, 1'b1);
        send(2, 1'b1, 1'b0);
        wait_store(2, 1'b0, 1'b1);
        chk("ract_clr", 0, ract[2]);
        chk("fin_clr", 0, fin[2]);
        chk("isr", 1, isr[2]);
        quiet(40, 1'b0);
        ctl(3, 8'h60);
        chk("inh0", 0, inh[3]);
        send(3, 1'b1, 1'b0);
        wait_store(3, 1'b0, 1'b1);
        wait_tx(3, 1'b0);
        wait_store(3, 1'b0, 1'b0);
        chk("fin_ans", 1, fin[3]);
        quiet(40, 1'b0);
        fail_next = 1'b1;
        ctl(1, 8'hA0);
        wait_tx(1, 1'b1);
        repeat (13) @(negedge clock_i);
        chk("tst_fail", 0, tst[1]);
        fail_next = 1'b0;
        wait_tx(1, 1'b1);
        repeat (20) @(negedge clock_i);
        send(1, 1'b0, 1'b0);
        wait_store(1, 1'b1, 1'b1);
        chk("fin_rx", 1, fin[1]);
        ctl(1, 8'hAE);
        chk("fin_ae", 0, fin[1]);
        repeat (2) begin
            send(1, 1'b0, 1'b0);
            wait_store(1, 1'b1, 1'b1);
        end
        chk("lost", 1, lost[1]);
        chk("fin_reread", 1, fin[1]);
        ctl(1, 8'h00);
        send(1, 1'b0, 1'b0);
        quiet(40, 1'b1);
        int_en = 1'b0;
        ctl(6, 8'hA0);
        ctl(4, 8'hA0);
        send(6, 1'b0, 1'b0);
        wait_store(6, 1'b1, 1'b1);
        int_en = 1'b1;
        wait_tx(4, 1'b1);
        repeat (20) @(negedge clock_i);
        quiet(60, 1'b0);
        basic_i = 1'b1;
        ctl(14, 8'h60);
        send(14, 1'b1, 1'b0);
        wait_store(14, 1'b0, 1'b1);
        quiet(60, 1'b0);
        complete_run();
    end
endmodule // can_slot_remote_frame_handling_bench
